/* rtl/iep_pkg.sv */
// Purpose: shared constants for the interrupt and exception priority unit
// Assumes: 16-bit status word, 3-bit level mask, 8 peripheral request lines
// Notes:   level code is {privilege, mask}; a lower code ranks higher
package iep_pkg;
	localparam int NPER = 8;
	localparam int NDMA = 16;
	// status word fields
	localparam int PS_P_BIT   = 7;
	localparam int PS_I_BIT   = 6;
	localparam int PS_S_BIT   = 5;
	localparam int PS_ILM_LSB = 13;
	localparam logic [15:0] PS_RST = 16'hE000;
	localparam logic [15:0] SSP_RST = 16'h0000;
	// vectors
	localparam logic [7:0] VEC_VECTOR9_TRAP_OPCODE = 8'h09;
	localparam logic [7:0] VEC_UNDEF = 8'h0A;
	localparam logic [7:0] VEC_NMI = 8'h0B;
	localparam logic [7:0] VEC_DELAYED = 8'h0C;
	localparam logic [7:0] VEC_PERIPH = 8'h0D;
	localparam logic [2:0] ILM_DEBUG = 3'h2;
	localparam logic [2:0] ILM_NMI = 3'h4;
	localparam logic [3:0] IDLE_USER_LEVEL = 4'hF;
	localparam logic [15:0] SSP_STEP = 16'h0002;
	localparam logic [15:0] RETURN_FROM_INTERRUPT_POP = 16'h000C;
	// context items and counts
	localparam logic [3:0] ITEM_AH = 4'h3;
	localparam logic [3:0] ITEM_PCB = 4'h9;
	localparam logic [3:0] N_LONG = 4'h9;
	localparam logic [3:0] N_NORMAL = 4'h6;
	localparam logic [3:0] N_SHORT = 4'h3;
	// apb map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_SSP = 8'h08;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam int CTRL_DBG_BIT = 0;
	localparam int CTRL_OCD_BIT = 1;
	localparam int CTRL_LONG_BIT = 2;
	localparam int CTRL_LVL_LSB = 4;
	typedef enum logic [1:0] {
		IEP_IDLE = 2'b00,
		IEP_PUSH = 2'b01,
		IEP_VEC  = 2'b11
	} iep_state_t;
	typedef enum logic [3:0] {
		K_NONE, K_TOOL, K_IB, K_NMI, K_PER, K_DLY, K_UNDEF, K_VECTOR9_TRAP_OPCODE, K_BREAKPOINT_OPCODE, K_SWI
	} iep_kind_t;
endpackage

/* rtl/iep_exc.sv */
// Purpose: ranks and accepts interrupts and exceptions, saves context, loads status
// Assumes: opcode pulses come only while the unit is idle; requests hold until served
// Notes:   one acceptance per instruction boundary; context leaves as a word stream
// How it works
// - higher-priority request preempts at instruction end
// - equal or lower level waits for mask change
// - dma grant held while busy, lowest channel wins
// - software trap always accepted, nests freely
// - instruction break: mask above 2, privilege set
// - nmi vector 11, level P4 entry
// - peripheral: mask above level, both flags set
// - delayed request yields to same-level peripheral
// - peripheral entry sets stack flag, mask, vector
// - tool break level comes from debug config
// - level code is privilege then mask
// - privilege flag is status bit 7
// - opcode exceptions accepted, hardware blocked meanwhile
// - undefined opcode traps vector 10, saves own address
// - six pushes, stack pointer drops two each
// - vector 9 trap saves pc plus one
// - breakpoint with debug unit enters debug vector
// - breakpoint without debug unit acts as undefined
// - legacy debug mode still decrements stack pointer
// - onchip debug saves long or short context
// - return restores full saved status
// - tool break before instruction break before nmi
module iep_exc (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// apb slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic [31:0]                        prdata,
	output logic                               pready,
	output logic                               pslverr,
	// instruction boundaries from the cpu
	input  wire logic                          instr_end,
	input  wire logic                          string_point,
	// hardware requests
	input  wire logic                          nmi_pin,
	input  wire logic                          ib_req,
	input  wire logic                          tool_req,
	input  wire logic [iep_pkg::NPER-1:0]      per_req,
	input  wire logic [3*iep_pkg::NPER-1:0]    per_level,
	input  wire logic                          dly_req,
	input  wire logic [2:0]                    dly_level,
	// opcode events
	input  wire logic                          op_undef,
	input  wire logic                          op_vector9_trap_opcode,
	input  wire logic                          op_breakpoint_opcode,
	input  wire logic                          op_swi,
	input  wire logic [7:0]                    op_swi_vec,
	input  wire logic                          op_return_from_interrupt,
	input  wire logic [15:0]                   return_from_interrupt_ps,
	// cpu context
	input  wire logic [15:0]                   ctx_acc_hi,
	input  wire logic [15:0]                   ctx_acc_lo,
	input  wire logic [15:0]                   ctx_dpr_adb,
	input  wire logic [15:0]                   ctx_dtb_pcb,
	input  wire logic [15:0]                   ctx_pc,
	input  wire logic [15:0]                   ctx_usb_ssb,
	input  wire logic [15:0]                   ctx_usp,
	// dma arbitration
	input  wire logic [iep_pkg::NDMA-1:0]      dma_req,
	input  wire logic                          dma_done,
	output logic [iep_pkg::NDMA-1:0]           dma_grant,
	// sequencer outputs
	output logic                               accept,
	output logic                               push_valid,
	output logic [15:0]                        push_data,
	output logic [15:0]                        push_addr,
	output logic                               push_debug,
	output logic                               vec_valid,
	output logic [7:0]                         vec_num,
	output logic                               vec_debug,
	output logic [15:0]                        ps_out,
	output logic [15:0]                        ssp_out
);
	iep_pkg::iep_state_t state_q, state_d;
	iep_pkg::iep_kind_t  kind_q, kind_d;
	logic [31:0] ctrl_q;
	logic [15:0] ps_q, new_ps_q, new_ps_d, save_ps_q, ssp_q, pc_save_q;
	logic [3:0]  cnt_q, nitems_q, start_q, nitems_d, start_d;
	logic        dbg_dst_q, dbg_dst_d, dec_q, dec_d, vdbg_q, vdbg_d;
	logic [7:0]  vec_q, vec_d;
	logic [1:0]  nmi_sync_q;
	logic        busy_dma_q;
	logic [iep_pkg::NDMA-1:0] grant_q, dma_pick;
	logic        push_v_q, vec_v_q, push_dbg_q;
	logic [15:0] push_d_q, push_a_q;

	// apb decode
	wire apb_acc = psel && penable;
	wire apb_wr = apb_acc && pwrite;
	wire hit_ctrl = paddr == iep_pkg::ADDR_CTRL;
	wire hit_stat = paddr == iep_pkg::ADDR_STATUS;
	wire hit_ssp = paddr == iep_pkg::ADDR_SSP;
	wire hit_any = hit_ctrl || hit_stat || hit_ssp;
	assign pready = 1'b1;
	assign pslverr = apb_acc && !hit_any;
	// read word is taken in the setup cycle so prdata leaves a flip-flop;
	// a status change in the access cycle itself shows on the next read
	wire [31:0] rd_word = hit_ctrl ? ctrl_q :
		hit_stat ? {16'h0000, ps_q} :
		hit_ssp ? {16'h0000, ssp_q} : 32'h0000_0000;
	logic [31:0] prdata_q;
	always_ff @(posedge clk) begin
		if (rst) prdata_q <= 32'h0000_0000;
		else prdata_q <= (psel && !penable) ? rd_word : apb_acc ? prdata_q : 32'h0000_0000;
	end
	assign prdata = prdata_q;

	// status fields
	wire       dbg_on = ctrl_q[iep_pkg::CTRL_DBG_BIT];
	wire       ocd = ctrl_q[iep_pkg::CTRL_OCD_BIT];
	wire       long_ctx = ctrl_q[iep_pkg::CTRL_LONG_BIT];
	wire [3:0] tool_lvl = ctrl_q[iep_pkg::CTRL_LVL_LSB +: 4];
	wire       priv = ps_q[iep_pkg::PS_P_BIT];
	wire       ien = ps_q[iep_pkg::PS_I_BIT];
	wire [2:0] interrupt_level_mask = ps_q[iep_pkg::PS_ILM_LSB +: 3];
	wire [3:0] cur_lvl = {priv, interrupt_level_mask};
	wire       idle = state_q == iep_pkg::IEP_IDLE;
	wire       any_pt = instr_end || string_point;

	// peripheral resolver: lowest level, then smallest number
	logic [2:0] per_best;
	logic [2:0] per_idx;
	logic       per_any;
	logic       per_same;
	always_comb begin
		per_best = 3'h7;
		per_idx = 3'h0;
		per_any = 1'b0;
		per_same = 1'b0;
		for (int i = 0; i < iep_pkg::NPER; i++) begin
			if (per_req[i] && (!per_any || per_level[3*i +: 3] < per_best)) begin
				per_best = per_level[3*i +: 3];
				per_idx = i[2:0];
				per_any = 1'b1;
			end
			if (per_req[i] && per_level[3*i +: 3] == dly_level) begin
				per_same = 1'b1;
			end
		end
	end

	// acceptance conditions
	wire hw_ok = idle && !op_undef && !op_vector9_trap_opcode && !op_breakpoint_opcode && !op_swi;
	wire ok_tool = tool_req && any_pt && (tool_lvl < cur_lvl);
	wire ok_ib = ib_req && instr_end && interrupt_level_mask > iep_pkg::ILM_DEBUG && priv;
	wire ok_nmi = nmi_sync_q[1] && any_pt && interrupt_level_mask > iep_pkg::ILM_NMI && priv;
	wire ok_per = per_any && any_pt && interrupt_level_mask > per_best && priv && ien;
	wire ok_dly = dly_req && any_pt && interrupt_level_mask > dly_level && priv && ien && !per_same;
	wire op_any = op_undef || op_vector9_trap_opcode || op_breakpoint_opcode || op_swi;
	assign accept = idle && (op_any || ok_tool || ok_ib || ok_nmi || ok_per || ok_dly);

	// selection of kind and entry status
	always_comb begin
		kind_d = iep_pkg::K_NONE;
		new_ps_d = ps_q;
		vec_d = 8'h00;
		vdbg_d = 1'b0;
		new_ps_d[iep_pkg::PS_S_BIT] = 1'b1;
		if (op_swi) begin
			kind_d = iep_pkg::K_SWI;
			vec_d = op_swi_vec;
			new_ps_d[iep_pkg::PS_I_BIT] = 1'b0;
		end else if (op_vector9_trap_opcode) begin
			kind_d = iep_pkg::K_VECTOR9_TRAP_OPCODE;
			vec_d = iep_pkg::VEC_VECTOR9_TRAP_OPCODE;
			new_ps_d[iep_pkg::PS_I_BIT] = 1'b0;
		end else if (op_breakpoint_opcode && dbg_on) begin
			kind_d = iep_pkg::K_BREAKPOINT_OPCODE;
			vdbg_d = 1'b1;
			new_ps_d[iep_pkg::PS_I_BIT] = 1'b0;
			new_ps_d[iep_pkg::PS_P_BIT] = 1'b0;
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = iep_pkg::ILM_DEBUG;
		end else if (op_undef || op_breakpoint_opcode) begin
			kind_d = iep_pkg::K_UNDEF;
			vec_d = iep_pkg::VEC_UNDEF;
			new_ps_d[iep_pkg::PS_I_BIT] = 1'b0;
		end else if (ok_tool) begin
			kind_d = iep_pkg::K_TOOL;
			vdbg_d = 1'b1;
			new_ps_d[iep_pkg::PS_P_BIT] = tool_lvl[3];
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = tool_lvl[2:0];
		end else if (ok_ib) begin
			kind_d = iep_pkg::K_IB;
			vdbg_d = 1'b1;
			new_ps_d[iep_pkg::PS_P_BIT] = 1'b0;
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = iep_pkg::ILM_DEBUG;
		end else if (ok_nmi) begin
			kind_d = iep_pkg::K_NMI;
			vec_d = iep_pkg::VEC_NMI;
			new_ps_d[iep_pkg::PS_P_BIT] = 1'b0;
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = iep_pkg::ILM_NMI;
		end else if (ok_per) begin
			kind_d = iep_pkg::K_PER;
			vec_d = iep_pkg::VEC_PERIPH + {5'h00, per_idx};
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = per_best;
		end else if (ok_dly) begin
			kind_d = iep_pkg::K_DLY;
			vec_d = iep_pkg::VEC_DELAYED;
			new_ps_d[iep_pkg::PS_ILM_LSB +: 3] = dly_level;
		end
	end

	// context form: debug kinds go to debug registers
	wire dbg_kind = kind_d == iep_pkg::K_TOOL || kind_d == iep_pkg::K_IB ||
		kind_d == iep_pkg::K_BREAKPOINT_OPCODE;
	wire ocd_form = dbg_kind && ocd;
	assign dbg_dst_d = dbg_kind;
	assign dec_d = !ocd_form;
	assign nitems_d = !ocd_form ? iep_pkg::N_NORMAL : long_ctx ? iep_pkg::N_LONG : iep_pkg::N_SHORT;
	assign start_d = (ocd_form && long_ctx) ? 4'h0 : iep_pkg::ITEM_AH;
	wire [15:0] pc_sel = (kind_d == iep_pkg::K_VECTOR9_TRAP_OPCODE) ? ctx_pc + 16'h0001 : ctx_pc;

	// item mux; short form walks code bank, pc, status
	wire        short_f = !dec_q && nitems_q == iep_pkg::N_SHORT;
	wire [3:0]  item = short_f ? (cnt_q == 4'h0 ? iep_pkg::ITEM_PCB : cnt_q + 4'h6) :
		start_q + cnt_q;
	logic [15:0] item_data;
	always_comb begin
		unique case (item)
			4'h0: item_data = ctx_usb_ssb;
			4'h1: item_data = ctx_usp;
			4'h2: item_data = ssp_q;
			4'h3: item_data = ctx_acc_hi;
			4'h4: item_data = ctx_acc_lo;
			4'h5: item_data = ctx_dpr_adb;
			4'h6: item_data = ctx_dtb_pcb;
			4'h7: item_data = pc_save_q;
			4'h8: item_data = save_ps_q;
			4'h9: item_data = {8'h00, ctx_dtb_pcb[7:0]};
			default: item_data = 16'h0000;
		endcase
	end
	wire last_item = cnt_q == nitems_q - 4'h1;
	wire [15:0] ssp_dec = ssp_q - iep_pkg::SSP_STEP;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			iep_pkg::IEP_IDLE: if (accept) state_d = iep_pkg::IEP_PUSH;
			iep_pkg::IEP_PUSH: if (last_item) state_d = iep_pkg::IEP_VEC;
			iep_pkg::IEP_VEC:  state_d = iep_pkg::IEP_IDLE;
			default:           state_d = iep_pkg::IEP_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= iep_pkg::IEP_IDLE;
			kind_q <= iep_pkg::K_NONE;
			cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (accept) kind_q <= kind_d;
			cnt_q <= (state_q == iep_pkg::IEP_PUSH && !last_item) ? cnt_q + 4'h1 : 4'h0;
		end
	end

	// captured entry data
	always_ff @(posedge clk) begin
		if (rst) begin
			new_ps_q <= iep_pkg::PS_RST;
			save_ps_q <= iep_pkg::PS_RST;
			pc_save_q <= 16'h0000;
			nitems_q <= iep_pkg::N_NORMAL;
			start_q <= iep_pkg::ITEM_AH;
			dbg_dst_q <= 1'b0;
			dec_q <= 1'b1;
			vec_q <= 8'h00;
			vdbg_q <= 1'b0;
		end else if (accept) begin
			new_ps_q <= new_ps_d;
			save_ps_q <= ps_q;
			pc_save_q <= pc_sel;
			nitems_q <= nitems_d;
			start_q <= start_d;
			dbg_dst_q <= dbg_dst_d;
			dec_q <= dec_d;
			vec_q <= vec_d;
			vdbg_q <= vdbg_d;
		end
	end

	// status word, stack pointer and control register
	always_ff @(posedge clk) begin
		if (rst) begin
			ps_q <= iep_pkg::PS_RST;
			ssp_q <= iep_pkg::SSP_RST;
			ctrl_q <= iep_pkg::CTRL_RST;
		end else begin
			if (state_q == iep_pkg::IEP_VEC) ps_q <= new_ps_q;
			else if (op_return_from_interrupt && idle) ps_q <= return_from_interrupt_ps;
			if (state_q == iep_pkg::IEP_PUSH && dec_q) ssp_q <= ssp_dec;
			else if (op_return_from_interrupt && idle) ssp_q <= ssp_q + iep_pkg::RETURN_FROM_INTERRUPT_POP;
			else if (apb_wr && hit_ssp) ssp_q <= pwdata[15:0];
			if (apb_wr && hit_ctrl) ctrl_q <= {24'h00_0000, pwdata[7:4], 1'b0, pwdata[2:0]};
		end
	end

	// push stream and vector pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			push_v_q <= 1'b0;
			push_d_q <= 16'h0000;
			push_a_q <= 16'h0000;
			push_dbg_q <= 1'b0;
			vec_v_q <= 1'b0;
		end else begin
			push_v_q <= state_q == iep_pkg::IEP_PUSH;
			if (state_q == iep_pkg::IEP_PUSH) begin
				push_d_q <= item_data;
				push_a_q <= dec_q ? ssp_dec : {12'h000, item};
				push_dbg_q <= dbg_dst_q;
			end
			vec_v_q <= state_q == iep_pkg::IEP_VEC;
		end
	end

	// nmi pin synchroniser
	always_ff @(posedge clk) begin
		if (rst) nmi_sync_q <= 2'b00;
		else nmi_sync_q <= {nmi_sync_q[0], nmi_pin};
	end

	// dma arbiter: lowest set bit
	assign dma_pick = dma_req & (~dma_req + 16'h0001);
	always_ff @(posedge clk) begin
		if (rst) begin
			grant_q <= 16'h0000;
			busy_dma_q <= 1'b0;
		end else if (!busy_dma_q || dma_done) begin
			grant_q <= (busy_dma_q ? 16'h0000 : dma_pick);
			busy_dma_q <= !busy_dma_q && |dma_req;
		end
	end

	assign dma_grant = grant_q;
	assign push_valid = push_v_q;
	assign push_data = push_d_q;
	assign push_addr = push_a_q;
	assign push_debug = push_dbg_q;
	assign vec_valid = vec_v_q;
	assign vec_num = vec_q;
	assign vec_debug = vdbg_q;
	assign ps_out = ps_q;
	assign ssp_out = ssp_q;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_PREEMPT: assert property (hw_ok && instr_end && per_any && priv && ien &&
		per_best < interrupt_level_mask && !ok_tool && !ok_ib && !ok_nmi |-> accept && kind_d == iep_pkg::K_PER)
		else $error("eligible peripheral not taken");
	AST_HOLD: assert property (accept && kind_d == iep_pkg::K_PER |-> per_best < interrupt_level_mask)
		else $error("peripheral taken at or below mask");
	AST_DMA_HOLD: assert property (busy_dma_q && !dma_done |=> $stable(grant_q))
		else $error("dma grant moved during transfer");
	AST_SWI: assert property (idle && op_swi |-> accept ##8
		(vec_v_q && vec_q == $past(op_swi_vec, 8))) else $error("software trap not vectored");
	AST_IB_PS: assert property (state_q == iep_pkg::IEP_VEC && kind_q == iep_pkg::K_IB |=>
		interrupt_level_mask == iep_pkg::ILM_DEBUG && !priv) else $error("instruction break status wrong");
	AST_NMI: assert property (accept && kind_d == iep_pkg::K_NMI |-> ##[4:11]
		(vec_v_q && vec_q == iep_pkg::VEC_NMI)) else $error("nmi vector wrong");
	AST_DLY: assert property (accept && kind_d == iep_pkg::K_DLY |-> !per_same && ien && priv)
		else $error("delayed taken over same-level peripheral");
	AST_BLOCK: assert property (idle && op_any |-> accept &&
		kind_d inside {iep_pkg::K_SWI, iep_pkg::K_VECTOR9_TRAP_OPCODE, iep_pkg::K_BREAKPOINT_OPCODE, iep_pkg::K_UNDEF})
		else $error("hardware request taken over an opcode exception");
	AST_SSP: assert property (push_v_q && dec_q |-> push_a_q == ssp_q)
		else $error("push address not decremented pointer");
	AST_VECTOR9_TRAP_OPCODE_PC: assert property (accept && kind_d == iep_pkg::K_VECTOR9_TRAP_OPCODE |=>
		pc_save_q == $past(ctx_pc) + 16'h0001) else $error("trap pc not plus one");
	COV_PER: cover property (accept && kind_d == iep_pkg::K_PER);
	COV_NEST: cover property (vec_v_q ##[1:20] accept && kind_d == iep_pkg::K_SWI);
	COV_SHORT: cover property (accept && ocd_form && !long_ctx);
endmodule // iep_exc

/* tb/iep_far_model.sv */
// Purpose: far-side model, cpu context source and stack sink
// Assumes: context registers stay constant during a test
// Notes:   pushes are logged in arrival order for the bench to inspect
module iep_far_model (
	// clock
	input  wire logic        clk,
	// context handed to the unit
	output logic [15:0]      ctx_acc_hi,
	output logic [15:0]      ctx_acc_lo,
	output logic [15:0]      ctx_dpr_adb,
	output logic [15:0]      ctx_dtb_pcb,
	output logic [15:0]      ctx_pc,
	output logic [15:0]      ctx_usb_ssb,
	output logic [15:0]      ctx_usp,
	// push stream from the unit
	input  wire logic        push_valid,
	input  wire logic [15:0] push_data,
	input  wire logic [15:0] push_addr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] data_q [$];
	logic [15:0] addr_q [$];
	// distinct words so a swapped item order shows up
	assign ctx_acc_hi = 16'h1111;
	assign ctx_acc_lo = 16'h2222;
	assign ctx_dpr_adb = 16'h3333;
	assign ctx_dtb_pcb = 16'h4444;
	assign ctx_pc = 16'h5550;
	assign ctx_usb_ssb = 16'h6666;
	assign ctx_usp = 16'h7777;
	always @(posedge clk) begin
		if (push_valid === 1'b1) begin
			data_q.push_back(push_data);
			addr_q.push_back(push_addr);
		end
	end
endmodule // iep_far_model

/* tb/tb_interrupt_exception_priority.sv */
// Purpose: directed bench for the interrupt and exception priority unit
// Assumes: instr_end held high except in the string-point check, so every idle cycle is a boundary
// Notes:   requests are dropped at the accept edge to avoid a second entry
module tb_interrupt_exception_priority;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, instr_end, string_point;
	logic nmi_pin, ib_req, tool_req, dly_req, op_undef, op_vector9_trap_opcode, op_breakpoint_opcode, op_swi, op_return_from_interrupt;
	logic dma_done, accept, push_valid, push_debug, vec_valid, vec_debug, rerr;
	logic [7:0] paddr, per_req, op_swi_vec, vec_num;
	logic [31:0] pwdata, prdata, rdat;
	logic [23:0] per_level;
	logic [2:0] dly_level;
	logic [15:0] return_from_interrupt_ps, push_data, push_addr, ps_out, ssp_out, dma_req, dma_grant;
	logic [15:0] ctx_acc_hi, ctx_acc_lo, ctx_dpr_adb, ctx_dtb_pcb, ctx_pc, ctx_usb_ssb, ctx_usp;
	logic [15:0] ctxv [6] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5550, 16'hE0C0};
	int errors = 0;
	int checks_done = 0;
	iep_exc iep_exc_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .instr_end, .string_point, .nmi_pin, .ib_req, .tool_req, .per_req,
		.per_level, .dly_req, .dly_level, .op_undef, .op_vector9_trap_opcode, .op_breakpoint_opcode, .op_swi, .op_swi_vec,
		.op_return_from_interrupt, .return_from_interrupt_ps, .ctx_acc_hi, .ctx_acc_lo, .ctx_dpr_adb, .ctx_dtb_pcb, .ctx_pc,
		.ctx_usb_ssb, .ctx_usp, .dma_req, .dma_done, .dma_grant, .accept, .push_valid,
		.push_data, .push_addr, .push_debug, .vec_valid, .vec_num, .vec_debug, .ps_out,
		.ssp_out);
	iep_far_model far_inst (.clk, .ctx_acc_hi, .ctx_acc_lo, .ctx_dpr_adb, .ctx_dtb_pcb,
		.ctx_pc, .ctx_usb_ssb, .ctx_usp, .push_valid, .push_data, .push_addr);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic close_out();
		if (errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	task automatic clr();
		{nmi_pin, ib_req, tool_req, dly_req, op_undef, op_vector9_trap_opcode, op_breakpoint_opcode, op_swi} <= 8'h00;
		per_req <= 8'h00;
	endtask
	task automatic op(input int k);
		@(posedge clk);
		case (k)
			1: op_undef <= 1'b1;
			2: op_vector9_trap_opcode <= 1'b1;
			3: op_breakpoint_opcode <= 1'b1;
			default: op_swi <= 1'b1;
		endcase
	endtask
	task automatic return_from_interrupt(input logic [15:0] ps);
		@(posedge clk);
		op_return_from_interrupt <= 1'b1;
		return_from_interrupt_ps <= ps;
		@(posedge clk);
		op_return_from_interrupt <= 1'b0;
	endtask
	// waits for acceptance, then checks vector, item count, status and stack pointer
	task automatic take(input logic [7:0] v, input logic dbg, input int n,
			input logic [15:0] ps, input logic [15:0] sp);
		int i;
		far_inst.data_q.delete();
		far_inst.addr_q.delete();
		@(negedge clk);
		for (i = 0; i < 20 && accept !== 1'b1; i++) @(negedge clk);
		chk(accept, 1'b1);
		@(posedge clk);
		clr();
		for (i = 0; i < 30 && vec_valid !== 1'b1; i++) @(negedge clk);
		chk({vec_debug, vec_num}, {dbg, v});
		chk(push_debug, dbg);
		@(negedge clk);
		chk(far_inst.data_q.size(), n);
		chk(ps_out, ps);
		chk(ssp_out, sp);
	endtask
	initial begin
		repeat (3000) @(posedge clk);
		errors++;
		close_out();
	end
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, instr_end, string_point, op_return_from_interrupt, dma_done} = 7'h00;
		{paddr, pwdata, per_level, dly_level, return_from_interrupt_ps, dma_req} = '0;
		op_swi_vec = 8'h40;
		clr();
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		instr_end <= 1'b1;
		rd(8'h04, 32'h0000_E000);
		return_from_interrupt(16'hE0C0);
		rd(8'h04, 32'h0000_E0C0);
		rd(8'h08, 32'h0000_000C);
		apb(1'b1, 8'h08, 32'h0000_0100);
		rd(8'h08, 32'h0000_0100);
		apb(1'b1, 8'h00, 32'h0000_00FF);
		rd(8'h00, 32'h0000_00F7);
		rd(8'h0C, 32'h0000_0000);
		chk(rerr, 1'b1);
		apb(1'b1, 8'h00, 32'h0000_0000);
		@(posedge clk);
		per_level <= 24'h01_80C0;
		per_req <= 8'h24;
		dly_req <= 1'b1;
		dly_level <= 3'h3;
		take(8'h0F, 1'b0, 6, 16'h60E0, 16'h00F4);
		for (int i = 0; i < 6; i++) begin
			chk(far_inst.data_q[i], ctxv[i]);
			chk(far_inst.addr_q[i], 16'(16'h00FE - 2 * i));
		end
		@(posedge clk);
		per_req <= 8'h20;
		repeat (10) begin
			@(negedge clk);
			chk(accept, 1'b0);
		end
		@(posedge clk);
		per_level[2:0] <= 3'h1;
		per_req <= 8'h21;
		take(8'h0D, 1'b0, 6, 16'h20E0, 16'h00E8);
		return_from_interrupt(16'h60E0);
		return_from_interrupt(16'hE0C0);
		@(posedge clk);
		dly_req <= 1'b1;
		dly_level <= 3'h5;
		take(8'h0C, 1'b0, 6, 16'hA0E0, 16'h00F4);
		return_from_interrupt(16'hE0C0);
		@(posedge clk);
		nmi_pin <= 1'b1;
		take(8'h0B, 1'b0, 6, 16'h8060, 16'h00F4);
		return_from_interrupt(16'hE0C0);
		op(1);
		per_req <= 8'h20;
		take(8'h0A, 1'b0, 6, 16'hE0A0, 16'h00F4);
		chk(far_inst.data_q[4], 16'h5550);
		return_from_interrupt(16'hE0C0);
		op(2);
		take(8'h09, 1'b0, 6, 16'hE0A0, 16'h00F4);
		chk(far_inst.data_q[4], 16'h5551);
		return_from_interrupt(16'hE0C0);
		op(3);
		take(8'h0A, 1'b0, 6, 16'hE0A0, 16'h00F4);
		return_from_interrupt(16'hE0C0);
		op(4);
		take(8'h40, 1'b0, 6, 16'hE0A0, 16'h00F4);
		op(4);
		take(8'h40, 1'b0, 6, 16'hE0A0, 16'h00E8);
		return_from_interrupt(16'hE0A0);
		return_from_interrupt(16'hE0C0);
		apb(1'b1, 8'h00, 32'h0000_0001);
		op(3);
		take(8'h00, 1'b1, 6, 16'h4020, 16'h00F4);
		return_from_interrupt(16'hE0C0);
		apb(1'b1, 8'h00, 32'h0000_0003);
		op(3);
		take(8'h00, 1'b1, 3, 16'h4020, 16'h0100);
		chk(far_inst.data_q[0], 16'h0044);
		return_from_interrupt(16'hE0C0);
		apb(1'b1, 8'h00, 32'h0000_0007);
		op(3);
		take(8'h00, 1'b1, 9, 16'h4020, 16'h010C);
		chk(far_inst.data_q[2], 16'h010C);
		return_from_interrupt(16'hE0C0);
		apb(1'b1, 8'h08, 32'h0000_0100);
		apb(1'b1, 8'h00, 32'h0000_0031);
		@(posedge clk);
		tool_req <= 1'b1;
		ib_req <= 1'b1;
		nmi_pin <= 1'b1;
		take(8'h00, 1'b1, 6, 16'h6060, 16'h00F4);
		return_from_interrupt(16'hE0C0);
		@(posedge clk);
		instr_end <= 1'b0;
		string_point <= 1'b1;
		ib_req <= 1'b1;
		repeat (4) begin
			@(negedge clk);
			chk(accept, 1'b0);
		end
		@(posedge clk);
		instr_end <= 1'b1;
		string_point <= 1'b0;
		take(8'h00, 1'b1, 6, 16'h4060, 16'h00F4);
		@(posedge clk);
		dma_req <= 16'h000A;
		repeat (3) @(negedge clk);
		chk(dma_grant, 16'h0002);
		@(posedge clk);
		dma_req <= 16'h000B;
		repeat (3) @(negedge clk);
		chk(dma_grant, 16'h0002);
		@(posedge clk);
		dma_done <= 1'b1;
		dma_req <= 16'h0009;
		@(posedge clk);
		dma_done <= 1'b0;
		repeat (3) @(negedge clk);
		chk(dma_grant, 16'h0001);
		close_out();
	end
endmodule // tb_interrupt_exception_priority
